//--- hw/psc_ctrl_regs.sv
`timescale 1ns/1ps
module psc_ctrl_regs (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire psc_pkg::psc_req_s crm_req_i,
  output psc_pkg::psc_rsp_s      crm_rsp_o,
  input  wire logic [1:0]        current_privilege_level_i,
  input  wire logic              long_mode_i,
  input  wire logic              flags_alignment_flag_i,
  input  wire logic              page_fault_i,
  input  wire logic [63:0]       page_fault_lin_addr_i,
  input  wire logic              task_switch_i,
  input  wire logic              clear_switched_instruction_i,
  input  wire logic              insn_valid_i,
  input  wire psc_pkg::psc_cls_e insn_cls_i,
  output psc_pkg::psc_dec_s      insn_dec_o,
  input  wire logic              fp_error_i,
  input  wire logic              fp_error_clear_i,
  input  wire logic              ignore_error_input_n_i,
  output logic                   error_output_pin_n_o,
  output logic                   fp_internal_report_o,
  input  wire logic [3:0]        irq_class_i,
  output logic                   irq_allowed_o,
  output logic [3:0]             priority_threshold_value_o,
  output logic                   paging_enable_o,
  output logic [63:0]            paging_structure_addr_o,
  output logic                   paging_cache_disable_o,
  output logic                   paging_write_through_o,
  output logic                   cache_fill_en_o,
  output logic                   write_back_hits_o,
  output logic                   inval_cycles_en_o,
  output logic                   align_check_o,
  output logic                   write_protect_o,
  output logic [63:0]            extension_enables_o
);

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0] sys_ctrl_r;
  logic [63:0] pf_addr_r;
  logic [63:0] pg_base_r;
  logic [63:0] ext_en_r;
  logic [3:0]  prio_thr_r;
  logic        ign_meta_r;
  logic        ign_sync_r;
  logic        fp_err_pend_r;

  logic        pe;
  logic        ts;
  logic        em;
  logic        mp;
  logic        ne;
  logic        cd;
  logic        nw;
  logic        ignore_err;

  assign pe         = sys_ctrl_r[psc_pkg::BIT_PE];
  assign ts         = sys_ctrl_r[psc_pkg::BIT_TS];
  assign em         = sys_ctrl_r[psc_pkg::BIT_EM];
  assign mp         = sys_ctrl_r[psc_pkg::BIT_MP];
  assign ne         = sys_ctrl_r[psc_pkg::BIT_NE];
  assign cd         = sys_ctrl_r[psc_pkg::BIT_CD];
  assign nw         = sys_ctrl_r[psc_pkg::BIT_NW];
  assign ignore_err = ~ign_sync_r;

  // ****************************************
  // Access checking
  // ****************************************
  function automatic logic idx_mapped(input logic [3:0] idx);
    idx_mapped = (idx == psc_pkg::IDX_SYS_CTRL) || (idx == psc_pkg::IDX_PF_ADDR) ||
                 (idx == psc_pkg::IDX_PG_BASE)  || (idx == psc_pkg::IDX_EXT_EN)  ||
                 (idx == psc_pkg::IDX_PRIO_THR);
  endfunction

  logic priv_bad;
  logic idx_bad;
  logic val_bad;
  logic acc_ok;
  logic wr_ok;

  always_comb begin
    priv_bad = pe && (current_privilege_level_i != psc_pkg::CPL_KERNEL);
    // Reserved slot and threshold outside 64-bit mode act as undefined
    idx_bad  = !idx_mapped(crm_req_i.idx) ||
               ((crm_req_i.idx == psc_pkg::IDX_PRIO_THR) && !long_mode_i);
    val_bad  = 1'b0;
    if (crm_req_i.write) begin
      if (crm_req_i.idx == psc_pkg::IDX_SYS_CTRL) begin
        val_bad = (crm_req_i.wdata[63:32] != psc_pkg::UPPER_ZERO) ||
                  (crm_req_i.wdata[psc_pkg::BIT_PG] && !crm_req_i.wdata[psc_pkg::BIT_PE]);
      end else if (crm_req_i.idx == psc_pkg::IDX_EXT_EN) begin
        val_bad = (crm_req_i.wdata[63:32] != psc_pkg::UPPER_ZERO);
      end
    end
    acc_ok = crm_req_i.valid && !priv_bad && !idx_bad && !val_bad;
    wr_ok  = acc_ok && crm_req_i.write;
  end

  // ****************************************
  // system_control_flags
  // ****************************************
  logic [31:0] scf_nxt;

  always_comb begin
    scf_nxt = sys_ctrl_r;
    if (wr_ok && (crm_req_i.idx == psc_pkg::IDX_SYS_CTRL)) begin
      scf_nxt = (crm_req_i.wdata[31:0] & psc_pkg::SCF_WMASK) | psc_pkg::SCF_FIXED;
    end
    if (clear_switched_instruction_i) begin
      scf_nxt[psc_pkg::BIT_TS] = 1'b0;
    end
    // Task switch wins over a clear or a load in the same cycle; no context is saved here
    if (task_switch_i) begin
      scf_nxt[psc_pkg::BIT_TS] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_ctrl_r <= psc_pkg::SCF_RESET;
    end else begin
      sys_ctrl_r <= scf_nxt;
    end
  end

  // ****************************************
  // page_fault_address
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pf_addr_r <= psc_pkg::REG64_RESET;
    end else if (page_fault_i) begin
      pf_addr_r <= page_fault_lin_addr_i;
    end else if (wr_ok && (crm_req_i.idx == psc_pkg::IDX_PF_ADDR)) begin
      pf_addr_r <= crm_req_i.wdata;
    end
  end

  // ****************************************
  // paging_structure_base and extension_enables
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_base_r <= psc_pkg::REG64_RESET;
    end else if (wr_ok && (crm_req_i.idx == psc_pkg::IDX_PG_BASE)) begin
      pg_base_r <= crm_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_en_r <= psc_pkg::REG64_RESET;
    end else if (wr_ok && (crm_req_i.idx == psc_pkg::IDX_EXT_EN)) begin
      ext_en_r <= crm_req_i.wdata;
    end
  end

  // ****************************************
  // interrupt_priority_threshold
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio_thr_r <= '0;
    end else if (wr_ok && (crm_req_i.idx == psc_pkg::IDX_PRIO_THR)) begin
      prio_thr_r <= crm_req_i.wdata[psc_pkg::PRIO_W-1:0];
    end
  end

  // ****************************************
  // Read answer
  // ****************************************
  logic [63:0] rd_val;

  always_comb begin
    case (crm_req_i.idx)
      psc_pkg::IDX_SYS_CTRL:  rd_val = {psc_pkg::UPPER_ZERO, sys_ctrl_r};
      psc_pkg::IDX_PF_ADDR:   rd_val = pf_addr_r;
      psc_pkg::IDX_PG_BASE:   rd_val = pg_base_r;
      psc_pkg::IDX_EXT_EN:    rd_val = ext_en_r;
      psc_pkg::IDX_PRIO_THR:  rd_val = {60'h0, prio_thr_r};
      default:                rd_val = psc_pkg::REG64_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crm_rsp_o <= '0;
    end else begin
      // Acknowledge only accepted moves; refused ones answer with a fault instead
      crm_rsp_o.ack      <= acc_ok;
      crm_rsp_o.gp_fault <= crm_req_i.valid && (priv_bad || (!idx_bad && val_bad));
      crm_rsp_o.ud_fault <= crm_req_i.valid && !priv_bad && idx_bad;
      crm_rsp_o.rdata    <= (acc_ok && !crm_req_i.write) ? rd_val : psc_pkg::REG64_RESET;
    end
  end

  // ****************************************
  // Ignore-error pin synchroniser
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ign_meta_r <= 1'b1;
      ign_sync_r <= 1'b1;
    end else begin
      ign_meta_r <= ignore_error_input_n_i;
      ign_sync_r <= ign_meta_r;
    end
  end

  // ****************************************
  // Floating-point error reporting
  // ****************************************
  logic fp_ext_err;
  logic fp_halt;

  assign fp_ext_err = fp_error_i && !ne && !ignore_err;
  assign fp_halt    = fp_err_pend_r && insn_valid_i &&
                      ((insn_cls_i == psc_pkg::CLS_FLOAT) || (insn_cls_i == psc_pkg::CLS_WAIT));

  // A new error wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fp_err_pend_r <= 1'b0;
    end else if (fp_ext_err) begin
      fp_err_pend_r <= 1'b1;
    end else if (fp_error_clear_i) begin
      fp_err_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      error_output_pin_n_o <= 1'b1;
      fp_internal_report_o <= 1'b0;
    end else begin
      error_output_pin_n_o <= !(fp_err_pend_r || fp_ext_err);
      fp_internal_report_o <= fp_error_i && ne;
    end
  end

  // ****************************************
  // Device-not-available decision
  // ****************************************
  // Decided from current flags only, so a faulting instruction never retires state
  logic nm_hit;
  logic ud_hit;

  always_comb begin
    nm_hit = 1'b0;
    ud_hit = 1'b0;
    case (insn_cls_i)
      psc_pkg::CLS_FLOAT: nm_hit = em || ts;
      psc_pkg::CLS_MEDIA: begin
        // Emulation turns packed-media into undefined; switched flag is then ignored
        ud_hit = em;
        nm_hit = !em && ts;
      end
      psc_pkg::CLS_WAIT:  nm_hit = mp && ts;
      psc_pkg::CLS_EXEMPT: nm_hit = 1'b0;
      default:            nm_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      insn_dec_o <= '0;
    end else begin
      insn_dec_o.valid    <= insn_valid_i;
      insn_dec_o.nm_fault <= insn_valid_i && nm_hit;
      insn_dec_o.ud_fault <= insn_valid_i && ud_hit;
      insn_dec_o.halt     <= fp_halt && !nm_hit && !ud_hit;
    end
  end

  // ****************************************
  // Mode and policy outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      paging_enable_o         <= 1'b0;
      paging_structure_addr_o <= psc_pkg::REG64_RESET;
      paging_cache_disable_o  <= 1'b0;
      paging_write_through_o  <= 1'b0;
    end else begin
      paging_enable_o         <= scf_nxt[psc_pkg::BIT_PG] && scf_nxt[psc_pkg::BIT_PE];
      paging_structure_addr_o <= {pg_base_r[63:psc_pkg::PGB_LSB], psc_pkg::PGB_LOW_ZERO};
      // Only data-cache policy of the first structure; translation caching is untouched.
      // Gated by next-state flags so they drop on the same edge as paging_enable_o
      paging_cache_disable_o  <= scf_nxt[psc_pkg::BIT_PG] && scf_nxt[psc_pkg::BIT_PE] &&
                                 !scf_nxt[psc_pkg::BIT_CD] && pg_base_r[psc_pkg::BIT_PCD];
      paging_write_through_o  <= scf_nxt[psc_pkg::BIT_PG] && scf_nxt[psc_pkg::BIT_PE] &&
                                 !scf_nxt[psc_pkg::BIT_CD] && pg_base_r[psc_pkg::BIT_PWT];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cache_fill_en_o   <= 1'b0;
      write_back_hits_o <= 1'b0;
      inval_cycles_en_o <= 1'b0;
      align_check_o     <= 1'b0;
      write_protect_o   <= 1'b0;
    end else begin
      cache_fill_en_o   <= !cd;
      write_back_hits_o <= !cd && !nw;
      inval_cycles_en_o <= !cd && !nw;
      // Virtual-8086 mode implies protection enable, so one test covers both
      align_check_o     <= sys_ctrl_r[psc_pkg::BIT_AM] && flags_alignment_flag_i &&
                           (current_privilege_level_i == psc_pkg::CPL_USER) && pe;
      write_protect_o   <= sys_ctrl_r[psc_pkg::BIT_WP];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      extension_enables_o        <= psc_pkg::REG64_RESET;
      priority_threshold_value_o <= '0;
      irq_allowed_o              <= 1'b0;
    end else begin
      extension_enables_o        <= ext_en_r;
      priority_threshold_value_o <= prio_thr_r;
      // Filtering holds in every mode, not only where the register is reachable
      irq_allowed_o              <= irq_class_i > prio_thr_r;
    end
  end

endmodule

//--- hw/psc_pkg.sv
package psc_pkg;

  // ****************************************
  // Control register indices
  // ****************************************
  localparam logic [3:0] IDX_SYS_CTRL  = 4'h0;
  localparam logic [3:0] IDX_RSVD_SLOT = 4'h1;
  localparam logic [3:0] IDX_PF_ADDR   = 4'h2;
  localparam logic [3:0] IDX_PG_BASE   = 4'h3;
  localparam logic [3:0] IDX_EXT_EN    = 4'h4;
  localparam logic [3:0] IDX_PRIO_THR  = 4'h8;

  // ****************************************
  // Field positions of system_control_flags
  // ****************************************
  localparam int BIT_PE = 0;
  localparam int BIT_MP = 1;
  localparam int BIT_EM = 2;
  localparam int BIT_TS = 3;
  localparam int BIT_ET = 4;
  localparam int BIT_NE = 5;
  localparam int BIT_WP = 16;
  localparam int BIT_AM = 18;
  localparam int BIT_NW = 29;
  localparam int BIT_CD = 30;
  localparam int BIT_PG = 31;

  // Bits software may change; ET is fixed and other bits read zero
  localparam logic [31:0] SCF_WMASK = 32'hE005_002F;
  localparam logic [31:0] SCF_RESET = 32'h0000_0010;
  localparam logic [31:0] SCF_FIXED = 32'h0000_0010;

  // ****************************************
  // Other fields and reset values
  // ****************************************
  localparam int          PGB_LSB      = 12;
  localparam int          BIT_PWT      = 3;
  localparam int          BIT_PCD      = 4;
  localparam int          PRIO_W       = 4;
  localparam logic [1:0]  CPL_KERNEL   = 2'h0;
  localparam logic [1:0]  CPL_USER     = 2'h3;
  localparam logic [63:0] REG64_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [31:0] UPPER_ZERO   = 32'h0000_0000;
  localparam logic [11:0] PGB_LOW_ZERO = 12'h000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_FLOAT,
    CLS_MEDIA,
    CLS_WAIT,
    CLS_EXEMPT
  } psc_cls_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  idx;
    logic [63:0] wdata;
  } psc_req_s;

  typedef struct packed {
    logic        ack;
    logic        gp_fault;
    logic        ud_fault;
    logic [63:0] rdata;
  } psc_rsp_s;

  typedef struct packed {
    logic valid;
    logic nm_fault;
    logic ud_fault;
    logic halt;
  } psc_dec_s;

endpackage

//--- sim/psc_ctrl_regs_checker.sv
`timescale 1ns/1ps
module psc_ctrl_regs_checker (
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire psc_pkg::psc_req_s crm_req_i,
  input wire psc_pkg::psc_rsp_s crm_rsp_o,
  input wire logic [1:0]        current_privilege_level_i,
  input wire logic              long_mode_i,
  input wire logic              insn_valid_i,
  input wire psc_pkg::psc_cls_e insn_cls_i,
  input wire psc_pkg::psc_dec_s insn_dec_o,
  input wire logic              fp_error_i,
  input wire logic              fp_internal_report_o,
  input wire logic [3:0]        irq_class_i,
  input wire logic              irq_allowed_o,
  input wire logic [3:0]        priority_threshold_value_o,
  input wire logic              paging_enable_o,
  input wire logic              paging_cache_disable_o,
  input wire logic              paging_write_through_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************
  // Register moves
  // ****************************************
  rsp_follow_a: assert property (
    crm_req_i.valid |=> (crm_rsp_o.ack || crm_rsp_o.gp_fault || crm_rsp_o.ud_fault))
    else $error("request left without response");
  rsp_idle_a: assert property (
    !crm_req_i.valid |=> !(crm_rsp_o.ack || crm_rsp_o.gp_fault || crm_rsp_o.ud_fault))
    else $error("response without request");
  rsvd_slot_a: assert property (
    crm_req_i.valid && crm_req_i.idx == psc_pkg::IDX_RSVD_SLOT && current_privilege_level_i == 2'h0
    |=> crm_rsp_o.ud_fault && !crm_rsp_o.ack) else $error("reserved slot accepted");
  thr_mode_a: assert property (
    crm_req_i.valid && crm_req_i.idx == psc_pkg::IDX_PRIO_THR && !long_mode_i && current_privilege_level_i == 2'h0
    |=> crm_rsp_o.ud_fault) else $error("threshold reached outside long mode");
  ext_type_a: assert property (
    crm_req_i.valid && !crm_req_i.write && crm_req_i.idx == psc_pkg::IDX_SYS_CTRL ##1 crm_rsp_o.ack
    |-> crm_rsp_o.rdata[psc_pkg::BIT_ET]) else $error("extension type read as zero");
  pcd_gate_a: assert property (
    !paging_enable_o |-> !paging_cache_disable_o && !paging_write_through_o)
    else $error("caching flags active without paging");
  // ****************************************
  // Instruction checks and errors
  // ****************************************
  dec_follow_a: assert property (
    insn_valid_i |=> insn_dec_o.valid) else $error("decision missing");
  exempt_a: assert property (
    insn_valid_i && insn_cls_i inside {psc_pkg::CLS_EXEMPT, psc_pkg::CLS_NONE}
    |=> !insn_dec_o.nm_fault && !insn_dec_o.ud_fault) else $error("exempt class faulted");
  halt_cls_a: assert property (
    insn_dec_o.halt |-> $past(insn_valid_i) && $past(insn_cls_i) inside {psc_pkg::CLS_FLOAT, psc_pkg::CLS_WAIT})
    else $error("halt on wrong class");
  int_rep_a: assert property (
    fp_internal_report_o |-> $past(fp_error_i)) else $error("internal report without error");
  irq_cmp_a: assert property (
    $past(nrst_i) |-> irq_allowed_o == ($past(irq_class_i) > priority_threshold_value_o))
    else $error("interrupt filter wrong");
  cover property (crm_rsp_o.gp_fault);
  cover property (insn_dec_o.nm_fault);
  cover property (insn_dec_o.halt);
endmodule

//--- sim/tb_psc_ctrl_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_psc_ctrl_regs;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  psc_pkg::psc_req_s crm_req_i = '0;
  psc_pkg::psc_rsp_s crm_rsp_o;
  logic [1:0]        current_privilege_level_i = 2'h0;
  logic              long_mode_i = 1'b1;
  logic              flags_alignment_flag_i = 1'b0;
  logic              page_fault_i = 1'b0;
  logic [63:0]       page_fault_lin_addr_i = 64'h0;
  logic              task_switch_i = 1'b0;
  logic              clear_switched_instruction_i = 1'b0;
  logic              insn_valid_i = 1'b0;
  psc_pkg::psc_cls_e insn_cls_i = psc_pkg::CLS_NONE;
  psc_pkg::psc_dec_s insn_dec_o;
  logic              fp_error_i = 1'b0;
  logic              fp_error_clear_i = 1'b0;
  logic              ignore_error_input_n_i = 1'b1;
  logic              error_output_pin_n_o, fp_internal_report_o, irq_allowed_o, paging_enable_o;
  logic [3:0]        irq_class_i = 4'h0;
  logic [3:0]        priority_threshold_value_o;
  logic [63:0]       paging_structure_addr_o, extension_enables_o;
  logic              paging_cache_disable_o, paging_write_through_o, cache_fill_en_o;
  logic              write_back_hits_o, inval_cycles_en_o, align_check_o, write_protect_o;
  // Model state
  logic [31:0]       scf;
  logic [63:0]       pfa, pgb, ext;
  logic [3:0]        thr, ri;
  logic [3:0]        idx_tab [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h6};
  int                bad_count, num_checks;

  psc_ctrl_regs u_dut (.*);

  always #4 clk_i = ~clk_i;

  task automatic final_report;
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic lv;
    // Policy outputs follow the stored registers one edge later; written flags reach paging_enable_o and gate the paging cache outputs on the same edge
    @(negedge clk_i);
    `CHK(paging_enable_o, scf[31])
    `CHK(paging_structure_addr_o, {pgb[63:12], 12'h000})
    `CHK({paging_cache_disable_o, paging_write_through_o}, {2{scf[31] & ~scf[30]}} & pgb[4:3])
    `CHK(write_protect_o, scf[16])
    `CHK(priority_threshold_value_o, thr)
    `CHK(extension_enables_o, ext)
    if (scf[30:29] == 2'b00) `CHK({cache_fill_en_o, write_back_hits_o, inval_cycles_en_o}, 3'h7)
  endtask

  task automatic acc(input logic w, input logic [3:0] i, input logic [63:0] d);
    psc_pkg::psc_rsp_s r;
    logic              gp, ud;
    logic [63:0]       rd;
    gp = scf[0] && current_privilege_level_i != 2'h0;
    ud = !gp && (!(i inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h8}) || (i == 4'h8 && !long_mode_i));
    if (!gp && !ud && w && (i == 4'h0 || i == 4'h4) && (d[63:32] != 0 || (i == 4'h0 && d[31] && !d[0])))
      gp = 1'b1;
    rd = 64'h0;
    @(negedge clk_i);
    crm_req_i = '{1'b1, w, i, d};
    @(negedge clk_i);
    r = crm_rsp_o;
    crm_req_i.valid = 1'b0;
    if (!gp && !ud) begin
      if (w) case (i)
        4'h0: scf = (d[31:0] & psc_pkg::SCF_WMASK) | psc_pkg::SCF_FIXED;
        4'h2: pfa = d;
        4'h3: pgb = d;
        4'h4: ext = d;
        default: thr = d[3:0];
      endcase
      else case (i)
        4'h0: rd = {32'h0, scf};
        4'h2: rd = pfa;
        4'h3: rd = pgb;
        4'h4: rd = ext;
        default: rd = {60'h0, thr};
      endcase
    end
    `CHK(r.ack, !gp && !ud)
    `CHK(r.gp_fault, gp)
    `CHK(r.ud_fault, ud)
    `CHK(r.rdata, rd)
    lv();
  endtask

  task automatic ins(input psc_pkg::psc_cls_e c, input logic hlt);
    logic nm, ud, ex;
    ud = c == psc_pkg::CLS_MEDIA && scf[2];
    nm = (c == psc_pkg::CLS_FLOAT && (scf[2] || scf[3])) || (c == psc_pkg::CLS_MEDIA && !scf[2] && scf[3])
      || (c == psc_pkg::CLS_WAIT && scf[1] && scf[3]);
    ex = hlt && !nm && (c == psc_pkg::CLS_FLOAT || c == psc_pkg::CLS_WAIT);
    @(negedge clk_i);
    insn_valid_i = 1'b1;
    insn_cls_i = c;
    @(negedge clk_i);
    insn_valid_i = 1'b0;
    `CHK(insn_dec_o, {1'b1, nm, ud, ex})
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    scf = psc_pkg::SCF_RESET;
    {pfa, pgb, ext, thr, bad_count, num_checks} = '0;
    void'($urandom(32'hB5B2));
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    for (int k = 0; k < 7; k++) acc(1'b0, idx_tab[k], 64'h0);
    acc(1'b1, 4'h0, 64'h8000_0000);
    acc(1'b1, 4'h0, 64'h1_0000_0001);
    acc(1'b1, 4'h0, 64'h8000_0001);
    current_privilege_level_i = 2'h3;
    acc(1'b0, 4'h0, 64'h0);
    acc(1'b1, 4'h2, 64'h5);
    current_privilege_level_i = 2'h0;
    long_mode_i = 1'b0;
    acc(1'b1, 4'h8, 64'h7);
    repeat (80) begin
      ri = idx_tab[$urandom % 7];
      current_privilege_level_i = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
      long_mode_i = 1'($urandom);
      acc(1'($urandom), ri, {($urandom % 8 == 0) ? $urandom : 32'h0, $urandom});
    end
    current_privilege_level_i = 2'h0;
    long_mode_i = 1'b1;
    acc(1'b1, 4'h0, 64'h1);
    pulse(task_switch_i);
    scf[3] = 1'b1;
    acc(1'b0, 4'h0, 64'h0);
    pulse(clear_switched_instruction_i);
    scf[3] = 1'b0;
    acc(1'b0, 4'h0, 64'h0);
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, 4'h0, (64'(k) << 1) | 64'(psc_pkg::SCF_FIXED));
      for (int c = 0; c < 5; c++) ins(psc_pkg::psc_cls_e'(c), 1'b0);
    end
    // Errors: external mode, then ignored, then internal
    acc(1'b1, 4'h0, 64'h0);
    pulse(fp_error_i);
    `CHK(error_output_pin_n_o, 1'b0)
    ins(psc_pkg::CLS_FLOAT, 1'b1);
    pulse(fp_error_clear_i);
    @(negedge clk_i);
    `CHK(error_output_pin_n_o, 1'b1)
    ignore_error_input_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    pulse(fp_error_i);
    `CHK({error_output_pin_n_o, fp_internal_report_o}, 2'b10)
    ignore_error_input_n_i = 1'b1;
    acc(1'b1, 4'h0, 64'h20);
    pulse(fp_error_i);
    `CHK({error_output_pin_n_o, fp_internal_report_o}, 2'b11)
    page_fault_lin_addr_i = {$urandom, $urandom};
    pulse(page_fault_i);
    pfa = page_fault_lin_addr_i;
    acc(1'b0, 4'h2, 64'h0);
    acc(1'b1, 4'h0, 64'h4_0001);
    current_privilege_level_i = 2'h3;
    flags_alignment_flag_i = 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK(align_check_o, 1'b1)
    flags_alignment_flag_i = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(align_check_o, 1'b0)
    current_privilege_level_i = 2'h0;
    acc(1'b1, 4'h8, 64'h5);
    irq_class_i = 4'h6;
    repeat (2) @(negedge clk_i);
    `CHK(irq_allowed_o, 1'b1)
    long_mode_i = 1'b0;
    irq_class_i = 4'h5;
    repeat (2) @(negedge clk_i);
    `CHK(irq_allowed_o, 1'b0)
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
endmodule

bind psc_ctrl_regs psc_ctrl_regs_checker u_chk (.*);
